// file: dv/ecp_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module ecp_eeprom_model (
  input wire logic clk_sys,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdo,
  output logic sdi,
  input wire logic [7:0] reply
);
  logic [7:0] shift_q;
  logic [7:0] got [16];
  logic [2:0] idx = 3'h0;
  logic idle_q = 1'b0;
  logic sck_last = 1'b0;
  int nbits = 0;
  int count = 0;
  // Deselected output toggles so a stale bit never passes for data
  always @(posedge clk_sys) idle_q <= ~idle_q;
  // One process owns the bit state; deselect restarts the byte
  always @(cs_n or sck) begin
    if (cs_n) begin
      idx = 3'h0;
      nbits = 0;
    end else if (sck && !sck_last) begin
      shift_q = {shift_q[6:0], sdo};
      nbits++;
      if (nbits % 8 == 0) begin
        got[count % 16] = shift_q;
        count++;
      end
    end else if (!sck && sck_last) begin
      idx = idx + 3'h1;
    end
    sck_last = sck;
  end
  assign sdi = cs_n ? idle_q : reply[3'h7 - idx];
endmodule
`default_nettype wire

// file: dv/eeprom_spi_and_serial_config_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t %s", $time, m); end end
module eeprom_spi_and_serial_config_port_tb;
  localparam int HB = 8;
  localparam logic [7:0] SCAN [4] = '{8'h00, 8'he0, 8'h1f, 8'h65};
  logic clk_sys = 1'b0;
  logic rst, m_scl, m_sda, stretched, sck_d;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, cs_n, wp_n, sck, sdo, sdi;
  logic [7:0] reply;
  logic [7:0] wbuf [4];
  logic [7:0] rbuf [4];
  int failures, check_count;
  int since = 0;
  int period = 0;
  // Open-drain lines with pull-ups
  wire scl_w = m_scl & (scl_oe_n | scl_o);
  wire sda_w = m_sda & (sda_oe_n | sda_o);

  always #2.5 clk_sys = ~clk_sys;

  ecp_top ecp_top_i (
    .clk_sys(clk_sys), .rst(rst),
    .two_wire_clock_line_i(scl_w), .two_wire_clock_line_o(scl_o),
    .two_wire_clock_line_oe_n(scl_oe_n),
    .two_wire_data_i(sda_w), .two_wire_data_o(sda_o), .two_wire_data_oe_n(sda_oe_n),
    .eeprom_chip_select_n(cs_n), .eeprom_write_protect_n(wp_n),
    .eeprom_sck(sck), .eeprom_sdo(sdo), .eeprom_sdi(sdi)
  );

  ecp_eeprom_model ecp_eeprom_model_i (
    .clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .sdo(sdo), .sdi(sdi), .reply(reply)
  );

  // Rise-to-rise spacing of the shift clock
  always @(posedge clk_sys) begin
    sck_d <= sck;
    since <= (sck && !sck_d) ? 1 : since + 1;
    if (sck && !sck_d) period <= since;
  end

  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic half();
    repeat (HB) @(posedge clk_sys);
  endtask

  // Waits out clock stretching, bounded
  task automatic scl_up();
    int n;
    n = 0;
    m_scl <= 1'b1;
    half();
    while (scl_w !== 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n > 0) stretched = 1'b1;
    if (n >= 20000) begin
      failures++;
      final_report();
    end
  endtask

  task automatic scl_dn();
    m_scl <= 1'b0;
    half();
  endtask

  task automatic start();
    m_sda <= 1'b1;
    half();
    scl_up();
    m_sda <= 1'b0;
    half();
    scl_dn();
  endtask

  task automatic stop();
    m_sda <= 1'b0;
    half();
    scl_up();
    m_sda <= 1'b1;
    half();
  endtask

  task automatic tx(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      m_sda <= b[i];
      half();
      scl_up();
      scl_dn();
    end
    m_sda <= 1'b1;
    half();
    scl_up();
    ack = ~sda_w;
    scl_dn();
  endtask

  task automatic rxb(input logic last, output logic [7:0] b);
    m_sda <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      half();
      scl_up();
      b[i] = sda_w;
      scl_dn();
    end
    m_sda <= last;
    half();
    scl_up();
    scl_dn();
  endtask

  task automatic wr(input logic [7:0] sub, input int n);
    logic ak;
    start();
    tx(8'h70, ak);
    `CHK(ak, 1'b1, "address not acked")
    tx(sub, ak);
    for (int i = 0; i < n; i++) begin
      tx(wbuf[i], ak);
      `CHK(ak, 1'b1, "data byte not acked")
    end
    stop();
  endtask

  task automatic rd(input logic [7:0] sub, input int n);
    logic ak;
    start();
    tx(8'h70, ak);
    tx(sub, ak);
    start();
    tx(8'h71, ak);
    `CHK(ak, 1'b1, "read address not acked")
    for (int i = 0; i < n; i++) rxb(i == n - 1, rbuf[i]);
    stop();
  endtask

  task automatic w1(input logic [7:0] sub, input logic [7:0] d);
    wbuf[0] = d;
    wr(sub, 1);
  endtask

  task automatic cr(input logic [7:0] sub, input logic [7:0] e);
    rd(sub, 1);
    `CHK(rbuf[0], e, "register readback")
  endtask

  task automatic wait_bytes(input int n);
    int k;
    k = 0;
    while (ecp_eeprom_model_i.count < n && k < 80000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 80000) begin
      failures++;
      final_report();
    end
  endtask

  initial begin
    int nb;
    int p;
    logic a;
    rst <= 1'b1;
    m_scl <= 1'b1;
    m_sda <= 1'b1;
    reply <= 8'ha5;
    failures = 0;
    check_count = 0;
    stretched = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK(cs_n, 1'b1, "select pin after reset")
    `CHK(wp_n, 1'b0, "protect pin after reset")
    cr(8'h00, 8'h01);
    cr(8'h03, 8'h96);
    cr(8'h07, 8'h00);
    start();
    tx(8'h72, a);
    stop();
    `CHK(a, 1'b0, "foreign address acked")
    w1(8'h00, 8'h00);
    `CHK(cs_n, 1'b0, "select pin not following write")
    // Six pushes at the slow reset rate overrun the four-entry queue
    for (int i = 0; i < 6; i++) w1(8'h01, 8'(8'h10 + i));
    `CHK(stretched, 1'b1, "full queue never held the clock")
    wait_bytes(6);
    cr(8'h02, 8'ha5);
    `CHK(period, 736, "reset shift period")
    for (int i = 0; i < 6; i++) `CHK(ecp_eeprom_model_i.got[i], 8'(8'h10 + i), "tx byte")
    w1(8'h02, 8'hff);
    cr(8'h02, 8'ha5);
    cr(8'h04, 8'h00);
    w1(8'h03, 8'h21);
    reply <= 8'h5a;
    wbuf[0] = 8'h02;
    wbuf[1] = 8'hc3;
    wr(8'h00, 2);
    `CHK(wp_n, 1'b1, "protect pin not following write")
    `CHK(cs_n, 1'b0, "select pin not following write")
    wait_bytes(7);
    // Finished exchange leaves only the new-byte flag up
    cr(8'h04, 8'h04);
    rd(8'h00, 3);
    `CHK(rbuf[0], 8'h02, "burst read byte 0")
    `CHK(rbuf[1], 8'hc3, "burst read byte 1")
    `CHK(rbuf[2], 8'h5a, "burst read byte 2")
    `CHK(ecp_eeprom_model_i.got[6], 8'hc3, "burst tx byte")
    nb = 7;
    for (int i = 0; i < 4; i++) begin
      w1(8'h03, SCAN[i]);
      w1(8'h01, 8'h00);
      nb++;
      wait_bytes(nb);
      cr(8'h03, SCAN[i]);
      p = (2 ** (SCAN[i][7:5] + 1)) * (SCAN[i][4:0] + 1);
      `CHK(period, p, "shift period")
    end
    final_report();
  end
endmodule
`default_nettype wire

// file: rtl/ecp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ecp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? '0 : AW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= (rd_q == LAST) ? '0 : AW'(rd_q + 1'b1);
      end
      if (push && !pop) begin
        cnt_q <= CW'(cnt_q + 1'b1);
      end else if (pop && !push) begin
        cnt_q <= CW'(cnt_q - 1'b1);
      end
    end
  end

  property p_fifo_full_stalls;
    @(posedge clk_sys) disable iff (rst)
      (cnt_q == FULL) && !pop |=> !in_ready;
  endproperty
  a_fifo_full_stalls: assert property (p_fifo_full_stalls) else $error("fifo full but ready");
endmodule
`default_nettype wire

// file: rtl/ecp_pkg.sv
package ecp_pkg;
  localparam logic [7:0] SLAVE_ADDR = 8'h70;
  localparam int SPI_BITS = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int PRE_W = 3;
  localparam int LIN_W = 5;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TX = 8'h01;
  localparam logic [7:0] OFF_RX = 8'h02;
  localparam logic [7:0] OFF_DIV = 8'h03;
  localparam logic [7:0] OFF_STAT = 8'h04;

  localparam int CTRL_SEL_POS = 0;
  localparam int CTRL_WP_POS = 1;
  localparam int DIV_PRE_LSB = 5;
  localparam int DIV_LIN_LSB = 0;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_PEND_POS = 1;
  localparam int STAT_RXNEW_POS = 2;
  localparam int STAT_FULL_POS = 3;

  localparam logic RST_SEL = 1'b1;
  localparam logic RST_WP = 1'b0;
  // 2^(4+1) * (22+1) = 736 input clock periods
  localparam logic [PRE_W-1:0] RST_PRESCALE = 3'h4;
  localparam logic [LIN_W-1:0] RST_DIVISOR = 5'h16;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [9:0] {
    ST_IDLE      = 10'h001,
    ST_ADDR      = 10'h002,
    ST_ADDR_ACK  = 10'h004,
    ST_SUB       = 10'h008,
    ST_SUB_ACK   = 10'h010,
    ST_WRITE     = 10'h020,
    ST_WR_HOLD   = 10'h040,
    ST_WRITE_ACK = 10'h080,
    ST_READ      = 10'h100,
    ST_READ_ACK  = 10'h200
  } ecp_i2c_st_t;
endpackage

// file: rtl/ecp_spi_shift.sv
`timescale 1ns/1ps
`default_nettype none
module ecp_spi_shift #(
  parameter int BITS = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ecp_pkg::PRE_W-1:0] prescale,
  input wire logic [ecp_pkg::LIN_W-1:0] divisor,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [BITS-1:0] in_byte,
  output logic sck,
  output logic sdo,
  input wire logic sdi,
  output logic [BITS-1:0] rx_byte,
  output logic rx_done,
  output logic busy
);
  import ecp_pkg::*;
  localparam int PCW = (1 << PRE_W) - 1;
  localparam int BCW = $clog2(BITS);
  localparam logic [BCW-1:0] LAST_BIT = BCW'(BITS - 1);

  logic sdi_m_q, sdi_s_q;
  logic busy_q, sck_q, done_q;
  logic [PCW-1:0] pre_q;
  logic [LIN_W-1:0] lin_q;
  logic [BCW-1:0] bit_q;
  logic [BITS-1:0] tx_q, rx_q, rxo_q;

  wire [PCW-1:0] pre_top = PCW'((32'd1 << prescale) - 32'd1);
  wire pre_end = (pre_q == pre_top);
  wire lin_end = (lin_q == divisor);
  wire tick = busy_q && pre_end && lin_end;
  wire start = in_valid && !busy_q;

  assign in_ready = !busy_q;
  assign sck = sck_q;
  assign sdo = tx_q[BITS-1];
  assign rx_byte = rxo_q;
  assign rx_done = done_q;
  assign busy = busy_q;

  always_ff @(posedge clk_sys) begin
    sdi_m_q <= sdi;
    sdi_s_q <= sdi_m_q;
  end

  // Half-period divider: 2^p cycles prescale, then divisor+1 of those
  always_ff @(posedge clk_sys) begin
    if (rst || start || !busy_q) begin
      pre_q <= '0;
      lin_q <= '0;
    end else if (pre_end) begin
      pre_q <= '0;
      lin_q <= lin_end ? '0 : LIN_W'(lin_q + 1'b1);
    end else begin
      pre_q <= PCW'(pre_q + 1'b1);
    end
  end

  always_ff @(posedge clk_sys) begin
    done_q <= 1'b0;
    if (rst) begin
      busy_q <= 1'b0;
      sck_q <= 1'b0;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      rxo_q <= '0;
    end else if (start) begin
      busy_q <= 1'b1;
      bit_q <= '0;
      tx_q <= in_byte;
    end else if (tick && !sck_q) begin
      sck_q <= 1'b1;
      rx_q <= {rx_q[BITS-2:0], sdi_s_q};
    end else if (tick) begin
      sck_q <= 1'b0;
      if (bit_q == LAST_BIT) begin
        busy_q <= 1'b0;
        rxo_q <= rx_q;
        done_q <= 1'b1;
      end else begin
        bit_q <= BCW'(bit_q + 1'b1);
        tx_q <= {tx_q[BITS-2:0], 1'b0};
      end
    end
  end

  // Assertion helpers: cycles since last half-period edge
  logic [12:0] cyc_q;
  logic cfg_chg_q;
  logic [PRE_W+LIN_W-1:0] cfg_prev_q;
  wire [12:0] half_len = 13'((32'd1 << prescale) * (32'(divisor) + 32'd1));
  always_ff @(posedge clk_sys) begin
    cfg_prev_q <= {prescale, divisor};
    if (rst || start || tick) begin
      cyc_q <= '0;
    end else begin
      cyc_q <= 13'(cyc_q + 1'b1);
    end
    if (rst || start) begin
      cfg_chg_q <= 1'b0;
    end else if (cfg_prev_q != {prescale, divisor}) begin
      cfg_chg_q <= 1'b1;
    end
  end

  property p_half_period;
    @(posedge clk_sys) disable iff (rst)
      tick && !cfg_chg_q && (cfg_prev_q == {prescale, divisor}) |-> 13'(cyc_q + 1'b1) == half_len;
  endproperty
  a_half_period: assert property (p_half_period) else $error("shift clock half period wrong");

  property p_sdo_msb;
    @(posedge clk_sys) disable iff (rst)
      start |=> sdo == $past(in_byte[BITS-1]);
  endproperty
  a_sdo_msb: assert property (p_sdo_msb) else $error("first data bit not MSB");

  property p_idle_low;
    @(posedge clk_sys) disable iff (rst)
      !busy_q |-> !sck_q;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("shift clock high while idle");

  property p_rx_capture;
    @(posedge clk_sys) disable iff (rst)
      $rose(sck_q) |-> rx_q[0] == $past(sdi_s_q);
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("sample not on rising edge");
endmodule
`default_nettype wire

// file: rtl/ecp_top.sv
`timescale 1ns/1ps
`default_nettype none
module ecp_top #(
  parameter int FIFO_W = 8,
  parameter int FIFO_N = ecp_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic two_wire_clock_line_i,
  output logic two_wire_clock_line_o,
  output logic two_wire_clock_line_oe_n,
  input wire logic two_wire_data_i,
  output logic two_wire_data_o,
  output logic two_wire_data_oe_n,
  output logic eeprom_chip_select_n,
  output logic eeprom_write_protect_n,
  output logic eeprom_sck,
  output logic eeprom_sdo,
  input wire logic eeprom_sdi
);
  import ecp_pkg::*;

  // Two-wire pin synchronisers; the second and third stages are read for edge detection
  logic scl_m_q, scl_s_q, scl_d_q;
  logic sda_m_q, sda_s_q, sda_d_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_d_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_m_q <= two_wire_clock_line_i;
      scl_s_q <= scl_m_q;
      scl_d_q <= scl_s_q;
      sda_m_q <= two_wire_data_i;
      sda_s_q <= sda_m_q;
      sda_d_q <= sda_s_q;
    end
  end

  wire scl_rise = scl_s_q && !scl_d_q;
  wire scl_fall = !scl_s_q && scl_d_q;
  wire bus_start = scl_s_q && scl_d_q && sda_d_q && !sda_s_q;
  wire bus_stop = scl_s_q && scl_d_q && !sda_d_q && sda_s_q;

  // Register state
  logic sel_q, wp_q;
  logic [PRE_W-1:0] pre_q;
  logic [LIN_W-1:0] lin_q;
  logic [7:0] tx_q;
  logic rx_new_q;

  // Serial slave state
  ecp_i2c_st_t st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] sub_q;
  logic rw_q;
  logic sda_low_q;

  // Datapath between register file and shifter
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [7:0] rx_byte;
  logic rx_done;
  logic spi_busy;

  wire addr_match = (sh_q[7:1] == SLAVE_ADDR[7:1]);
  wire in_hold = (st_q == ST_WR_HOLD);
  wire tx_target = (sub_q == OFF_TX);
  // Writes to the transmit byte stall with SCL held low while the queue is full
  wire can_commit = !tx_target || fifo_in_ready;
  wire wr_commit = in_hold && can_commit;
  wire fifo_in_valid = in_hold && tx_target;

  // Next read address looks one ahead during the master's acknowledge
  wire [7:0] rd_addr = (st_q == ST_READ_ACK) ? 8'(sub_q + 8'h01) : sub_q;
  wire [7:0] rd_ctrl = 8'(({7'h00, wp_q} << CTRL_WP_POS) | ({7'h00, sel_q} << CTRL_SEL_POS));
  wire [7:0] rd_div = 8'(({5'h00, pre_q} << DIV_PRE_LSB) | ({3'h0, lin_q} << DIV_LIN_LSB));
  wire [7:0] rd_stat = 8'(({7'h00, spi_busy} << STAT_BUSY_POS)
                       | ({7'h00, fifo_out_valid} << STAT_PEND_POS)
                       | ({7'h00, rx_new_q} << STAT_RXNEW_POS)
                       | ({7'h00, !fifo_in_ready} << STAT_FULL_POS));
  wire [7:0] rd_data = (rd_addr == OFF_CTRL) ? rd_ctrl :
                       (rd_addr == OFF_TX) ? tx_q :
                       (rd_addr == OFF_RX) ? rx_byte :
                       (rd_addr == OFF_DIV) ? rd_div :
                       (rd_addr == OFF_STAT) ? rd_stat : 8'h00;

  // Loading a read byte happens on these falling edges
  wire rd_first = scl_fall && (st_q == ST_ADDR_ACK) && rw_q;
  wire rd_next = scl_fall && (st_q == ST_READ_ACK);
  wire rd_take = (rd_first || rd_next) && (rd_addr == OFF_RX);

  assign two_wire_clock_line_o = 1'b0;
  assign two_wire_clock_line_oe_n = !in_hold;
  assign two_wire_data_o = 1'b0;
  assign two_wire_data_oe_n = !sda_low_q;
  assign eeprom_chip_select_n = sel_q;
  assign eeprom_write_protect_n = wp_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= ST_IDLE;
      bit_q <= '0;
      sh_q <= '0;
      rw_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (bus_start) begin
      st_q <= ST_ADDR;
      bit_q <= '0;
      sda_low_q <= 1'b0;
    end else if (bus_stop) begin
      st_q <= ST_IDLE;
      sda_low_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          sda_low_q <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s_q};
            bit_q <= 4'(bit_q + 1'b1);
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_q <= '0;
            if (addr_match) begin
              sda_low_q <= 1'b1;
              rw_q <= sh_q[0];
              st_q <= ST_ADDR_ACK;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall && rw_q) begin
            sh_q <= rd_data;
            sda_low_q <= !rd_data[7];
            st_q <= ST_READ;
          end else if (scl_fall) begin
            sda_low_q <= 1'b0;
            st_q <= ST_SUB;
          end
        end
        ST_SUB: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s_q};
            bit_q <= 4'(bit_q + 1'b1);
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_q <= '0;
            sda_low_q <= 1'b1;
            st_q <= ST_SUB_ACK;
          end
        end
        ST_SUB_ACK, ST_WRITE_ACK: begin
          if (scl_fall) begin
            sda_low_q <= 1'b0;
            st_q <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s_q};
            bit_q <= 4'(bit_q + 1'b1);
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_q <= '0;
            st_q <= ST_WR_HOLD;
          end
        end
        ST_WR_HOLD: begin
          if (can_commit) begin
            sda_low_q <= 1'b1;
            st_q <= ST_WRITE_ACK;
          end
        end
        ST_READ: begin
          if (scl_rise) begin
            bit_q <= 4'(bit_q + 1'b1);
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_q <= '0;
            sda_low_q <= 1'b0;
            st_q <= ST_READ_ACK;
          end else if (scl_fall) begin
            sh_q <= {sh_q[6:0], 1'b0};
            sda_low_q <= !sh_q[6];
          end
        end
        ST_READ_ACK: begin
          // A not-acknowledge ends the read; wait for stop or start
          if (scl_rise && sda_s_q) begin
            st_q <= ST_IDLE;
          end else if (scl_fall) begin
            sh_q <= rd_data;
            sda_low_q <= !rd_data[7];
            st_q <= ST_READ;
          end
        end
        default: begin
          st_q <= ST_IDLE;
          sda_low_q <= 1'b0;
        end
      endcase
    end
  end

  // Sub-address: loaded after the first write byte, then stepped per byte
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sub_q <= '0;
    end else if (st_q == ST_SUB && scl_fall && bit_q == 4'h8) begin
      sub_q <= sh_q;
    end else if (wr_commit || rd_next) begin
      sub_q <= 8'(sub_q + 8'h01);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_q <= RST_SEL;
      wp_q <= RST_WP;
      pre_q <= RST_PRESCALE;
      lin_q <= RST_DIVISOR;
      tx_q <= RST_BYTE;
    end else if (wr_commit) begin
      if (sub_q == OFF_CTRL) begin
        sel_q <= sh_q[CTRL_SEL_POS];
        wp_q <= sh_q[CTRL_WP_POS];
      end
      if (sub_q == OFF_DIV) begin
        pre_q <= sh_q[DIV_PRE_LSB +: PRE_W];
        lin_q <= sh_q[DIV_LIN_LSB +: LIN_W];
      end
      if (tx_target) begin
        tx_q <= sh_q;
      end
    end
  end

  // New-byte flag: a finishing exchange wins over a read that clears it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_new_q <= 1'b0;
    end else if (rx_done) begin
      rx_new_q <= 1'b1;
    end else if (rd_take) begin
      rx_new_q <= 1'b0;
    end
  end

  ecp_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_N)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(sh_q),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  ecp_spi_shift #(
    .BITS(SPI_BITS)
  ) u_spi (
    .clk_sys(clk_sys),
    .rst(rst),
    .prescale(pre_q),
    .divisor(lin_q),
    .in_valid(fifo_out_valid),
    .in_ready(fifo_out_ready),
    .in_byte(fifo_out_data),
    .sck(eeprom_sck),
    .sdo(eeprom_sdo),
    .sdi(eeprom_sdi),
    .rx_byte(rx_byte),
    .rx_done(rx_done),
    .busy(spi_busy)
  );

  property p_addr_reject;
    @(posedge clk_sys) disable iff (rst)
      (st_q == ST_ADDR) && scl_fall && (bit_q == 4'h8) && !addr_match && !bus_start && !bus_stop
      |=> (st_q == ST_IDLE) && two_wire_data_oe_n;
  endproperty
  a_addr_reject: assert property (p_addr_reject) else $error("foreign address answered");

  property p_sub_step;
    @(posedge clk_sys) disable iff (rst)
      wr_commit && !bus_start && !bus_stop |=> sub_q == 8'($past(sub_q) + 8'h01);
  endproperty
  a_sub_step: assert property (p_sub_step) else $error("sub-address did not advance");

  property p_cs_follow;
    @(posedge clk_sys) disable iff (rst)
      wr_commit && (sub_q == OFF_CTRL) |=> eeprom_chip_select_n == $past(sh_q[CTRL_SEL_POS]);
  endproperty
  a_cs_follow: assert property (p_cs_follow) else $error("chip select late");

  property p_wp_follow;
    @(posedge clk_sys) disable iff (rst)
      wr_commit && (sub_q == OFF_CTRL) |=> eeprom_write_protect_n == $past(sh_q[CTRL_WP_POS]);
  endproperty
  a_wp_follow: assert property (p_wp_follow) else $error("write protect wrong");

  sequence s_tx_push;
    wr_commit && tx_target;
  endsequence
  sequence s_exchange_starts;
    ##[1:2] spi_busy;
  endsequence
  property p_tx_starts;
    @(posedge clk_sys) disable iff (rst)
      s_tx_push and !spi_busy && !fifo_out_valid |-> s_exchange_starts;
  endproperty
  a_tx_starts: assert property (p_tx_starts) else $error("exchange not started");
endmodule
`default_nettype wire
